// >>> hw/i2ces_top.v
`timescale 1ns/1ps
`default_nettype none
`include "i2ces_regs.vh"

// Summary of operation
// - Hard reset or self-reset restores all fields
// - Software access blocked during boot EEPROM load
// - Boot loading may replace register reset values
// - Direction bit: 0 read, 1 write
// - Byte address selects location within page
// - Page select picks 256-byte page
// - Target type code addresses device, resets 1010
// - Start launches operation, self-clears when finished
module i2ces_top #(
	parameter ADDR_W = 17
) (
	// Clock and reset
	input  wire              clk,
	input  wire              rst,
	input  wire              hard_reset_input_n,
	input  wire              self_reset,
	// AXI4-Lite write address channel
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	// AXI4-Lite write data channel
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	// AXI4-Lite write response channel
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	// AXI4-Lite read address channel
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	// AXI4-Lite read data channel
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// Boot-time EEPROM register loader
	input  wire              boot_load_active,
	input  wire              boot_wr_en,
	input  wire [ADDR_W-1:0] boot_wr_addr,
	input  wire [31:0]       boot_wr_data,
	// Transfer engine
	output wire              op_start_ff,
	output wire              op_busy_ff,
	output wire              op_dir_ff,
	output wire [7:0]        op_byte_addr_ff,
	output wire [2:0]        op_page_ff,
	output wire [3:0]        target_type_code_ff,
	input  wire              op_done
);

	localparam [ADDR_W-1:0] SETUP_ADDR = `I2CES_SETUP_ADDR;
	localparam [ADDR_W-1:0] CTRL_ADDR  = `I2CES_CTRL_ADDR;

	function is_setup;
		input [ADDR_W-1:0] a;
		begin
			is_setup = ({a[ADDR_W-1:2], 2'b00} == SETUP_ADDR);
		end
	endfunction

	function is_ctrl;
		input [ADDR_W-1:0] a;
		begin
			is_ctrl = ({a[ADDR_W-1:2], 2'b00} == CTRL_ADDR);
		end
	endfunction

	// Merges the strobed bytes of a write into the old value.
	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer i;
		begin
			merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = new_v[i*8 +: 8];
				end
			end
		end
	endfunction

	// Hard reset pin synchroniser.
	reg hrst_meta_ff;
	reg hrst_sync_ff;

	always @(posedge clk) begin
		if (rst) begin
			hrst_meta_ff <= 1'b1;
			hrst_sync_ff <= 1'b1;
		end else begin
			hrst_meta_ff <= hard_reset_input_n;
			hrst_sync_ff <= hrst_meta_ff;
		end
	end

	wire clr = rst | ~hrst_sync_ff | self_reset;

	// Register state and held write request.
	reg  [31:0]       setup_ff;
	reg               done_ff;
	reg  [ADDR_W-1:0] awaddr_ff;
	reg  [31:0]       wdata_ff;
	reg  [3:0]        wstrb_ff;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	// A write executes once both halves are held and no response is pending.
	wire wr_go   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire wr_ok   = !boot_load_active && (is_setup(awaddr_ff) || is_ctrl(awaddr_ff));
	wire rd_ok   = !boot_load_active && (is_setup(s_axi_araddr) || is_ctrl(s_axi_araddr));

	wire [31:0] wr_merged_setup = merge(setup_ff, wdata_ff, wstrb_ff);
	wire [31:0] wr_merged_ctrl  = merge(32'h00000000, wdata_ff, wstrb_ff);
	wire        ctrl_wr         = wr_go && wr_ok && is_ctrl(awaddr_ff);
	wire        launch          = ctrl_wr && wr_merged_ctrl[`I2CES_START_BIT];
	wire        done_w1c        = ctrl_wr && wr_merged_ctrl[`I2CES_DONE_BIT];
	wire        done_evt        = op_busy_ff && op_done;

	// Transfer setup register.
	always @(posedge clk) begin
		if (clr) begin
			setup_ff <= `I2CES_SETUP_RESET;
		end else if (boot_load_active) begin
			if (boot_wr_en && is_setup(boot_wr_addr)) begin
				setup_ff <= boot_wr_data & `I2CES_SETUP_WMASK;
			end
		end else if (wr_go && wr_ok && is_setup(awaddr_ff)) begin
			// Reserved bits are never stored, so they always read as zero.
			setup_ff <= wr_merged_setup & `I2CES_SETUP_WMASK;
		end
	end

	// Completion flag: write one clears, but a completion in the same cycle wins.
	always @(posedge clk) begin
		if (clr) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= (done_ff & ~done_w1c) | done_evt;
		end
	end

	// Write channels.
	always @(posedge clk) begin
		if (clr) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `I2CES_RESP_OKAY;
			awaddr_ff     <= {ADDR_W{1'b0}};
			wdata_ff      <= 32'h00000000;
			wstrb_ff      <= 4'h0;
		end else begin
			if (aw_take) begin
				s_axi_awready <= 1'b0;
				awaddr_ff     <= s_axi_awaddr;
			end
			if (w_take) begin
				s_axi_wready <= 1'b0;
				wdata_ff     <= s_axi_wdata;
				wstrb_ff     <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `I2CES_RESP_OKAY : `I2CES_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read channels.
	reg [31:0] rd_word;

	always @* begin
		rd_word = 32'h00000000;
		if (is_setup(s_axi_araddr)) begin
			rd_word = setup_ff;
		end else if (is_ctrl(s_axi_araddr)) begin
			rd_word[`I2CES_DONE_BIT]   = done_ff;
			rd_word[`I2CES_START_BIT]  = op_busy_ff;
			rd_word[`I2CES_RDSTAT_BIT] = op_busy_ff & ~op_dir_ff;
			rd_word[`I2CES_WRSTAT_BIT] = op_busy_ff & op_dir_ff;
		end
	end

	always @(posedge clk) begin
		if (clr) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `I2CES_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			// A blocked or unmapped read returns zero data with an error.
			s_axi_rdata   <= rd_ok ? rd_word : 32'h00000000;
			s_axi_rresp   <= rd_ok ? `I2CES_RESP_OKAY : `I2CES_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	i2ces_launch u_launch (
		.clk          (clk),
		.clr          (clr),
		.launch       (launch),
		.dir          (setup_ff[`I2CES_DIR_BIT]),
		.byte_addr    (setup_ff[`I2CES_BADDR_HI:`I2CES_BADDR_LO]),
		.page         (setup_ff[`I2CES_PAGE_HI:`I2CES_PAGE_LO]),
		.type_code    (setup_ff[`I2CES_TYPE_HI:`I2CES_TYPE_LO]),
		.done         (op_done),
		.start_ff     (op_start_ff),
		.busy_ff      (op_busy_ff),
		.dir_ff       (op_dir_ff),
		.byte_addr_ff (op_byte_addr_ff),
		.page_ff      (op_page_ff),
		.type_code_ff (target_type_code_ff)
	);

endmodule // i2ces_top

`default_nettype wire

// >>> hw/i2ces_regs.vh
`ifndef I2CES_REGS_VH
`define I2CES_REGS_VH

// Register byte addresses.
`define I2CES_SETUP_ADDR        17'h1AB00
`define I2CES_CTRL_ADDR         17'h1AB04

// Transfer setup register layout, bit 0 being the least significant bit.
`define I2CES_SETUP_RESET       32'h0000000A
`define I2CES_SETUP_WMASK       32'h01FF070F
`define I2CES_DIR_BIT           24
`define I2CES_BADDR_HI          23
`define I2CES_BADDR_LO          16
`define I2CES_PAGE_HI           10
`define I2CES_PAGE_LO           8
`define I2CES_TYPE_HI           3
`define I2CES_TYPE_LO           0
`define I2CES_TYPE_RESET        4'hA

// Companion control register layout.
`define I2CES_CTRL_RESET        32'h00000000
`define I2CES_DONE_BIT          28
`define I2CES_RDSTAT_BIT        17
`define I2CES_WRSTAT_BIT        16
`define I2CES_START_BIT         8

// AXI4-Lite response codes.
`define I2CES_RESP_OKAY         2'h0
`define I2CES_RESP_SLVERR       2'h2

`endif

// >>> hw/i2ces_launch.v
`timescale 1ns/1ps
`default_nettype none
`include "i2ces_regs.vh"

module i2ces_launch (
	// Clock and clear
	input  wire        clk,
	input  wire        clr,
	// Launch request and settings to capture
	input  wire        launch,
	input  wire        dir,
	input  wire [7:0]  byte_addr,
	input  wire [2:0]  page,
	input  wire [3:0]  type_code,
	// Completion from the transfer engine
	input  wire        done,
	// Captured settings and status
	output reg         start_ff,
	output reg         busy_ff,
	output reg         dir_ff,
	output reg  [7:0]  byte_addr_ff,
	output reg  [2:0]  page_ff,
	output reg  [3:0]  type_code_ff
);

	always @(posedge clk) begin
		if (clr) begin
			start_ff     <= 1'b0;
			busy_ff      <= 1'b0;
			dir_ff       <= 1'b0;
			byte_addr_ff <= 8'h00;
			page_ff      <= 3'h0;
			type_code_ff <= `I2CES_TYPE_RESET;
		end else begin
			start_ff <= 1'b0;
			if (launch && !busy_ff) begin
				// Settings are frozen here so later register writes cannot
				// disturb a transfer that is already running.
				start_ff     <= 1'b1;
				busy_ff      <= 1'b1;
				dir_ff       <= dir;
				byte_addr_ff <= byte_addr;
				page_ff      <= page;
				type_code_ff <= type_code;
			end else if (busy_ff && done) begin
				busy_ff <= 1'b0;
			end
		end
	end

endmodule // i2ces_launch

`default_nettype wire

// >>> verif/i2ces_props.sv
`timescale 1ns/1ps
`default_nettype none
module i2ces_props (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Register bus
	input wire logic       boot_load_active,
	input wire logic       s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_rvalid,
	input wire logic [1:0] s_axi_rresp,
	// Transfer engine
	input wire logic       op_start_ff,
	input wire logic       op_busy_ff,
	input wire logic       op_done,
	input wire logic       op_dir_ff,
	input wire logic [7:0] op_byte_addr_ff,
	input wire logic [2:0] op_page_ff,
	input wire logic [3:0] target_type_code_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_pulse; op_busy_ff ##1 !op_start_ff; endsequence
	sequence s_bwr; boot_load_active ##1 boot_load_active ##1 $rose(s_axi_bvalid); endsequence
	// Reset itself is the cause here, so this one must not be disabled by it.
	property p_rst; disable iff (1'h0) rst |=> target_type_code_ff == 4'hA && !op_busy_ff;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_launch; op_start_ff |-> s_pulse; endproperty
	a_launch: assert property (p_launch) else $error("bad launch pulse");
	property p_idle; op_start_ff |-> !$past(op_busy_ff); endproperty
	a_idle: assert property (p_idle) else $error("launch while busy");
	property p_rise; $rose(op_busy_ff) |-> op_start_ff; endproperty
	a_rise: assert property (p_rise) else $error("busy without launch");
	property p_done; op_busy_ff && op_done |=> !op_busy_ff; endproperty
	a_done: assert property (p_done) else $error("busy after done");
	property p_hold; op_busy_ff ##1 op_busy_ff |->
		$stable({op_dir_ff, op_byte_addr_ff, op_page_ff, target_type_code_ff}); endproperty
	a_hold: assert property (p_hold) else $error("settings moved");
	property p_wblk; s_bwr |-> s_axi_bresp == 2'h2; endproperty
	a_wblk: assert property (p_wblk) else $error("write not blocked");
	property p_rblk; boot_load_active ##1 $rose(s_axi_rvalid) |-> s_axi_rresp == 2'h2; endproperty
	a_rblk: assert property (p_rblk) else $error("read not blocked");
endmodule // i2ces_props
bind i2ces_top i2ces_props u_props (.*);
`default_nettype wire

// >>> verif/i2ces_eng_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2ces_eng_model (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Engine handshake; dly sets how long the transfer takes
	input wire logic       op_start_ff,
	input wire logic [4:0] dly,
	output var logic       op_done
);
	logic [4:0] cnt_ff;
	logic       run_ff;
	always @(posedge clk) begin
		op_done <= 1'h0;
		if (rst) run_ff <= 1'h0;
		else if (op_start_ff) begin
			run_ff <= 1'h1;
			cnt_ff <= dly;
		end else if (run_ff && cnt_ff == 5'h00) begin
			run_ff  <= 1'h0;
			op_done <= 1'h1;
		end else if (run_ff) cnt_ff <= cnt_ff - 5'h01;
	end
endmodule // i2ces_eng_model
`default_nettype wire

// >>> verif/i2c_eeprom_command_setup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_eeprom_command_setup_tb;
	logic        clk, rst, hard_reset_input_n, self_reset, s_axi_awvalid, s_axi_wvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_rready, boot_load_active, boot_wr_en;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        op_start_ff, op_busy_ff, op_dir_ff, op_done;
	logic [16:0] s_axi_awaddr, s_axi_araddr, boot_wr_addr;
	logic [31:0] s_axi_wdata, boot_wr_data, s_axi_rdata, lf, d, q, e;
	logic [7:0]  op_byte_addr_ff;
	logic [4:0]  dly;
	logic [3:0]  s_axi_wstrb, target_type_code_ff;
	logic [2:0]  op_page_ff;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          miscompares, cmp_count, i, n;
	i2ces_top i_dut (.*);
	i2ces_eng_model i_eng (.clk, .rst, .op_start_ff, .dly, .op_done);
	function automatic [31:0] nx(input [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Reserved setup bits never stick.
	function automatic [31:0] ex(input [31:0] v);
		return v & 32'h01FF070F;
	endfunction
	function automatic [15:0] cap(input [31:0] v);
		return {v[24], v[23:16], v[10:8], v[3:0]};
	endfunction
	task automatic chk(input string s, input [31:0] e, input [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(input [16:0] a, input [31:0] v, output [1:0] rr);
		logic ka, kw;
		ka = 0;
		kw = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(ka && kw)) begin
			@(posedge clk);
			if (s_axi_awready && !ka) s_axi_awvalid <= 1'h0;
			if (s_axi_wready && !kw) s_axi_wvalid <= 1'h0;
			ka |= s_axi_awready;
			kw |= s_axi_wready;
		end
		do @(posedge clk); while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input [16:0] a, output [31:0] v, output [1:0] rr);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		miscompares++;
		print_verdict;
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{boot_load_active, boot_wr_en, boot_wr_addr, boot_wr_data, self_reset} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, dly} = 0;
		s_axi_wstrb = 4'hF;
		hard_reset_input_n = 1;
		rst = 1;
		lf = 32'h0000004D;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		rd(17'h1AB00, q, r);
		chk("setup", 32'h0000000A, q);
		for (i = 0; i < 8; i++) begin
			lf = nx(lf);
			d = (i == 1) ? 32'hFFFFFFFF : (i == 2) ? 32'h0 : lf;
			dly <= (i == 0) ? 5'h00 : lf[4:0] | 5'h08;
			wr(17'h1AB00, d, r);
			rd(17'h1AB00, q, r);
			chk("setup", ex(d), q);
			chk("rresp", 0, r);
			// Launch and clear the previous completion flag in one write.
			wr(17'h1AB04, 32'h10000100, r);
			chk("bresp", 0, r);
			@(posedge clk);
			chk("busy", 1, op_busy_ff);
			// Overwrite mid-transfer, or after completion when dly is 0; the captured copy must not follow it.
			wr(17'h1AB00, ~d, r);
			rd(17'h1AB04, q, r);
			e = (i == 0) ? 32'h8 : {29'h0, ~d[24], d[24], 1'b1};
			chk("stat", e, {q[28], q[17:16], q[8]});
			for (n = 0; n < 80 && op_busy_ff !== 0; n++) @(posedge clk);
			chk("capt", cap(d), {op_dir_ff, op_byte_addr_ff, op_page_ff, target_type_code_ff});
			rd(17'h1AB04, q, r);
			chk("ctrl", 32'h8, {q[28], q[17:16], q[8]});
		end
		rd(17'h1AB10, q, r);
		chk("rresp", 2, {q[31:2], r});
		@(posedge clk);
		boot_load_active <= 1'h1;
		boot_wr_en <= 1'h1;
		boot_wr_addr <= 17'h1AB00;
		boot_wr_data <= lf;
		@(posedge clk);
		boot_wr_en <= 1'h0;
		wr(17'h1AB00, 32'h0, r);
		chk("bresp", 2, r);
		rd(17'h1AB00, q, r);
		chk("rresp", 2, r);
		boot_load_active <= 1'h0;
		rd(17'h1AB00, q, r);
		chk("boot", ex(lf), q);
		self_reset <= 1'h1;
		@(posedge clk);
		self_reset <= 1'h0;
		rd(17'h1AB00, q, r);
		chk("self", 32'h0000000A, q);
		wr(17'h1AB00, lf, r);
		hard_reset_input_n <= 1'h0;
		repeat (3) @(posedge clk);
		hard_reset_input_n <= 1'h1;
		repeat (4) @(posedge clk);
		rd(17'h1AB00, q, r);
		chk("hard", 32'h0000000A, q);
		print_verdict;
	end
endmodule // i2c_eeprom_command_setup_tb
`default_nettype wire
